/* hw/twl_edge.v */
/*
 * rising edge detector for a serial input pin.
 * assumes the pin is already synchronous to clk.
 */
`timescale 1ns/10ps
module twl_edge (
    input wire clk,
    input wire nrst,
    input wire pin,
    output reg level,
    output wire rise
);
    // ============================================================
    // edge detect
    reg prev;

    always @(posedge clk) begin
        if (!nrst) begin
            // start from the pin so a level already high at reset is not taken as an edge
            prev <= pin;
            level <= pin;
        end else begin
            prev <= pin;
            level <= pin;
        end
    end

    assign rise = pin & ~prev;
endmodule

/* hw/twl_loader.v */
/*
 * three-wire serial programming port: 24-bit shift register, four latches,
 * chip enable power-down, charge pump three-state and monitor multiplexer.
 * assumes serial clock, data, load strobe and chip enable are synchronous
 * to clk and each serial clock level lasts at least two clk cycles.
 * the latch fields beyond power-down, pump three-state and monitor select
 * are not decoded here; the latches are presented as plain outputs.
 */
// Summary of operation
// - data is shifted into the 24-bit shift register on each rising serial clock edge.
// - words arrive most significant bit first, the first bit ending at the top.
// - the last two bits sent are the two low bits and select the latch.
// - a rising load strobe copies the shift register into the selected one of four latches.
// - while chip enable is low the device is powered down whatever the latches hold.
// - while chip enable is low the charge pump output is three-stated.
// - with chip enable high the device powers up only as far as the power-down bits allow.
// - the monitor output shows lock detect, the divided feedback clock, the divided reference clock, or a constant high or low.
// - select 00 is control, 01 reference counter, 10 feedback counter, 11 test mode latch.
`timescale 1ns/10ps
`include "twl_regs.vh"
module twl_loader (
    input wire clk,
    input wire nrst,
    input wire serial_clock,
    input wire serial_data,
    input wire latch_load_strobe,
    input wire chip_enable,
    input wire lock_detect,
    input wire feedback_div_clock,
    input wire reference_div_clock,
    output reg [23:0] control_latch,
    output reg [23:0] refcnt_latch,
    output reg [23:0] fbcnt_latch,
    output reg [23:0] test_latch,
    output reg [3:0] latch_written,
    output reg powered_up,
    output reg charge_pump_enable,
    output reg charge_pump_output_oe,
    output reg monitor_output
);
    // ============================================================
    // pin edges
    wire sclk_rise;
    wire load_rise;

    twl_edge u_sclk (
        .clk(clk),
        .nrst(nrst),
        .pin(serial_clock),
        .level(),
        .rise(sclk_rise)
    );

    twl_edge u_load (
        .clk(clk),
        .nrst(nrst),
        .pin(latch_load_strobe),
        .level(),
        .rise(load_rise)
    );

    // ============================================================
    // shift register
    reg [`TWL_WORD_W-1:0] shift_word;
    wire [1:0] latch_sel;
    wire latch_select_high;
    wire latch_select_low;

    // data is taken in the cycle the rising serial clock is seen, so it must already stand there
    always @(posedge clk) begin
        if (!nrst) begin
            shift_word <= `TWL_LATCH_RESET;
        end else if (sclk_rise) begin
            shift_word <= {shift_word[`TWL_WORD_W-2:0], serial_data};
        end
    end

    assign latch_select_high = shift_word[`TWL_SEL_HI];
    assign latch_select_low = shift_word[`TWL_SEL_LO];
    assign latch_sel = {latch_select_high, latch_select_low};

    // ============================================================
    // latch transfer
    // a short or long word still loads; the latch is picked by whatever bits ended at the bottom
    reg [3:0] next_written;

    always @* begin
        next_written = 4'h0;
        if (load_rise) begin
            case (latch_sel)
                `TWL_SEL_CONTROL: begin
                    next_written = 4'h1;
                end
                `TWL_SEL_REFCNT: begin
                    next_written = 4'h2;
                end
                `TWL_SEL_FBCNT: begin
                    next_written = 4'h4;
                end
                `TWL_SEL_TEST: begin
                    next_written = 4'h8;
                end
                default: begin
                    next_written = 4'h0;
                end
            endcase
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            latch_written <= 4'h0;
        end else begin
            latch_written <= next_written;
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            control_latch <= `TWL_LATCH_RESET;
        end else if (next_written[0]) begin
            control_latch <= shift_word;
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            refcnt_latch <= `TWL_LATCH_RESET;
        end else if (next_written[1]) begin
            refcnt_latch <= shift_word;
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            fbcnt_latch <= `TWL_LATCH_RESET;
        end else if (next_written[2]) begin
            fbcnt_latch <= shift_word;
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            test_latch <= `TWL_LATCH_RESET;
        end else if (next_written[3]) begin
            test_latch <= shift_word;
        end
    end

    // ============================================================
    // power and charge pump
    // chip enable gates the power-down bits; the bits can keep parts off, never turn them on
    wire core_power_down;
    wire pump_three_state;
    wire next_powered_up;
    wire next_pump_oe;

    assign core_power_down = control_latch[`TWL_CTL_CORE_PD];
    assign pump_three_state = control_latch[`TWL_CTL_CP_3STATE];
    assign next_powered_up = chip_enable & ~core_power_down;
    assign next_pump_oe = chip_enable & ~pump_three_state;

    // power-down is read from the latch, so a fresh load takes effect next cycle
    always @(posedge clk) begin
        if (!nrst) begin
            powered_up <= 1'b0;
        end else begin
            powered_up <= next_powered_up;
        end
    end

    // the pump bias follows the core: no pump current while the core is down
    always @(posedge clk) begin
        if (!nrst) begin
            charge_pump_enable <= 1'b0;
        end else begin
            charge_pump_enable <= next_powered_up;
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            charge_pump_output_oe <= 1'b0;
        end else begin
            charge_pump_output_oe <= next_pump_oe;
        end
    end

    // ============================================================
    // monitor multiplexer
    wire [2:0] mon_sel;
    reg next_monitor;

    assign mon_sel = control_latch[`TWL_CTL_MON_HI:`TWL_CTL_MON_LO];

    always @* begin
        case (mon_sel)
            `TWL_MON_LOCK: begin
                next_monitor = lock_detect;
            end
            `TWL_MON_FB: begin
                next_monitor = feedback_div_clock;
            end
            `TWL_MON_REF: begin
                next_monitor = reference_div_clock;
            end
            `TWL_MON_HIGH: begin
                next_monitor = 1'b1;
            end
            `TWL_MON_LOW: begin
                next_monitor = 1'b0;
            end
            // unused select codes park the pin low rather than leave it floating
            default: begin
                next_monitor = 1'b0;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!nrst) begin
            monitor_output <= 1'b0;
        end else begin
            monitor_output <= next_monitor;
        end
    end
endmodule

/* hw/twl_regs.vh */
/*
 * constants for the three-wire latch loader: word size, latch select codes,
 * latch reset values and monitor select codes.
 * assumes it is included by bare name from the design files under hw/.
 */
`ifndef TWL_REGS_VH
`define TWL_REGS_VH

// ============================================================
// word layout
`define TWL_WORD_W 24
`define TWL_SEL_HI 1
`define TWL_SEL_LO 0

// ============================================================
// latch select codes
`define TWL_SEL_CONTROL 2'h0
`define TWL_SEL_REFCNT 2'h1
`define TWL_SEL_FBCNT 2'h2
`define TWL_SEL_TEST 2'h3

// ============================================================
// reset values
`define TWL_LATCH_RESET 24'h00_0000

// ============================================================
// control latch fields used here
`define TWL_CTL_MON_HI 7
`define TWL_CTL_MON_LO 5
`define TWL_CTL_CORE_PD 20
`define TWL_CTL_CP_3STATE 3
`define TWL_MON_LOCK 3'h1
`define TWL_MON_FB 3'h2
`define TWL_MON_REF 3'h4
`define TWL_MON_HIGH 3'h3
`define TWL_MON_LOW 3'h7

`endif

/* testbench/tb.sv */
/* testbench for twl_loader.
   assumes twl_host drives the serial lines. */
`timescale 1ns/10ps
module tb;
    reg clk, nrst, chip_enable;
    reg [2:0] mi;
    wire sclk, sdat, strobe, pu, pe, oe, mon;
    wire [23:0] cl, rl, fl, tl;
    wire [3:0] wr;
    wire [95:0] all_l = {tl, fl, rl, cl};
    integer n_fail, cmp_count;
    twl_host i_host (.clk(clk), .serial_clock(sclk), .serial_data(sdat), .latch_load_strobe(strobe));
    twl_loader i_dut (.clk(clk), .nrst(nrst), .serial_clock(sclk), .serial_data(sdat), .latch_load_strobe(strobe),
        .chip_enable(chip_enable), .lock_detect(mi[0]), .feedback_div_clock(mi[1]), .reference_div_clock(mi[2]),
        .control_latch(cl), .refcnt_latch(rl), .fbcnt_latch(fl), .test_latch(tl), .latch_written(wr),
        .powered_up(pu), .charge_pump_enable(pe), .charge_pump_output_oe(oe), .monitor_output(mon));
    // ============================================================
    // shared tasks
    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", cmp_count, n_fail);
            if (n_fail == 0 && cmp_count > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task chk(input [63:0] nm, input [23:0] e, input [23:0] g);
        begin
            cmp_count = cmp_count + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("unexpected %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task load(input [23:0] w, input integer k);
        integer n;
        begin
            i_host.send(w);
            n = 0;
            while (wr === 4'h0 && n < 20) begin
                @(negedge clk);
                n = n + 1;
            end
            if (wr === 4'h0) begin
                chk("written", 24'h1 << k, 24'(wr));
                give_verdict;
            end else begin
                chk("written", 24'h1 << k, 24'(wr));
                chk("latch", w, all_l[k*24 +: 24]);
            end
        end
    endtask
    task wait_chk(input [23:0] ep, input [23:0] eo);
        begin
            repeat (3) @(negedge clk);
            chk("power", ep, 24'(pu));
            chk("pump_en", ep, 24'(pe));
            chk("pump", eo, 24'(oe));
        end
    endtask
    // ============================================================
    // scenarios
    task t_order;
        begin
            load(24'hC3_3C01, 1);
            load(24'h0F_00F4, 0);
            load(24'h80_0006, 2);
            load(24'h55_5553, 3);
            $display("latch order test done");
        end
    endtask
    task t_power;
        begin
            @(posedge clk) chip_enable <= 1'b1;
            wait_chk(24'h1, 24'h1);
            @(posedge clk) chip_enable <= 1'b0;
            wait_chk(24'h0, 24'h0);
            @(posedge clk) chip_enable <= 1'b1;
            load(24'h10_0000, 0);
            wait_chk(24'h0, 24'h1);
            $display("power test done");
        end
    endtask
    task t_monitor;
        integer k;
        begin
            for (k = 0; k < 3; k = k + 1) begin
                load({16'h0000, 3'h1 << k, 5'h00}, 0);
                @(posedge clk) mi <= 3'h1 << k;
                repeat (2) @(negedge clk);
                chk("monitor", 24'h1, 24'(mon));
                @(posedge clk) mi <= ~(3'h1 << k);
                repeat (2) @(negedge clk);
                chk("monitor", 24'h0, 24'(mon));
            end
            load({16'h0000, 3'h3, 5'h00}, 0);
            repeat (2) @(negedge clk);
            chk("monitor", 24'h1, 24'(mon));
            $display("monitor test done");
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        nrst = 1'b0;
        chip_enable = 1'b0;
        mi = 3'h0;
        n_fail = 0;
        cmp_count = 0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        t_order;
        t_power;
        t_monitor;
        give_verdict;
    end
endmodule
bind twl_loader twl_chk i_chk (.clk(clk), .nrst(nrst), .latch_load_strobe(latch_load_strobe),
    .chip_enable(chip_enable), .lock_detect(lock_detect), .control_latch(control_latch),
    .refcnt_latch(refcnt_latch), .fbcnt_latch(fbcnt_latch), .latch_written(latch_written),
    .powered_up(powered_up), .charge_pump_output_oe(charge_pump_output_oe), .monitor_output(monitor_output));

/* testbench/twl_host.sv */
/* host model driving the serial lines.
   assumes clk is the loader clock; each serial level lasts two cycles. */
`timescale 1ns/10ps
module twl_host (
    input wire clk,
    output reg serial_clock,
    output reg serial_data,
    output reg latch_load_strobe
);
    // ============================================================
    // word send, strobe left high until next word
    initial begin
        serial_clock = 1'b0;
        serial_data = 1'b0;
        latch_load_strobe = 1'b0;
    end
    task send(input [23:0] w);
        integer i;
        begin
            for (i = 23; i >= 0; i = i - 1) begin
                @(posedge clk);
                latch_load_strobe <= 1'b0;
                serial_data <= w[i];
                @(posedge clk);
                serial_clock <= 1'b1;
                repeat (2) @(posedge clk);
                serial_clock <= 1'b0;
            end
            @(posedge clk);
            serial_data <= ~w[0];
            latch_load_strobe <= 1'b1;
        end
    endtask
endmodule

/* testbench/twl_loader_asserts.sv */
/* port checker for twl_loader.
   assumes it is bound to twl_loader from tb. */
`timescale 1ns/10ps
module twl_chk (
    input wire clk,
    input wire nrst,
    input wire latch_load_strobe,
    input wire chip_enable,
    input wire lock_detect,
    input wire [23:0] control_latch,
    input wire [23:0] refcnt_latch,
    input wire [23:0] fbcnt_latch,
    input wire [3:0] latch_written,
    input wire powered_up,
    input wire charge_pump_output_oe,
    input wire monitor_output
);
    // ============================================================
    // properties
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    power_down_a: assert property (!chip_enable |=> !powered_up) else $error("powered while off");
    pump_off_a: assert property (!chip_enable |=> !charge_pump_output_oe) else $error("pump driven");
    power_up_a: assert property (chip_enable && !control_latch[20] |=> powered_up) else $error("no power");
    load_pulse_a: assert property ($rose(latch_load_strobe) |=> $onehot(latch_written)) else $error("no load");
    ref_sel_a: assert property (latch_written[1] |-> refcnt_latch[1:0] == 2'h1) else $error("bad ref");
    fb_sel_a: assert property (latch_written[2] |-> fbcnt_latch[1:0] == 2'h2) else $error("bad fb");
    ref_hold_a: assert property (!latch_written[1] |-> $stable(refcnt_latch)) else $error("ref moved");
    mon_lock_a: assert property (control_latch[7:5] == 3'h1 |=> monitor_output == $past(lock_detect))
        else $error("monitor wrong");
    cover property ($rose(latch_load_strobe));
    cover property (!chip_enable ##1 chip_enable);
    cover property (control_latch[7:5] == 3'h1);
endmodule
